/* File: omda_far_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// converter and line model at the far side of the block
// ---------------------------------------------------------------
module omda_far_model
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ai_conv_start,
   input wire logic [omda_pkg::CH_IDX_WIDTH-1:0] ai_conv_sel,
   input wire logic [omda_pkg::DIO_LINES-1:0] dio_pin_out,
   input wire logic [omda_pkg::DIO_LINES-1:0] dio_pin_oe,
   input wire logic [omda_pkg::DIO_LINES-1:0] ext_level,
   output logic ai_adc_valid,
   output logic signed [omda_pkg::AI_CAL_WIDTH-1:0] ai_adc_code,
   output logic [omda_pkg::DIO_LINES-1:0] dio_pin_in
);
   import omda_pkg::*;
   logic [1:0] wait_cnt;
   logic [CH_IDX_WIDTH-1:0] sel_hold;
   // a line reads the block where it drives, else the outside driver
   assign dio_pin_in = (dio_pin_oe & dio_pin_out) | (~dio_pin_oe & ext_level);
   // answer two cycles after a start; idle code lines flip so a stale word never matches
   always @(negedge clk)
   begin
      if (sys_rst)
      begin
         wait_cnt = 2'h0;
         ai_adc_valid = 1'b0;
         ai_adc_code = '0;
      end
      else
      begin
         ai_adc_valid = (wait_cnt == 2'h1);
         ai_adc_code = (wait_cnt == 2'h1) ? (24'sh0a0000 | {20'h0, sel_hold}) : ~ai_adc_code;
         wait_cnt = (wait_cnt != 2'h0) ? wait_cnt - 2'h1 : 2'h0;
         if (ai_conv_start === 1'b1)
         begin
            sel_hold = ai_conv_sel;
            wait_cnt = 2'h2;
         end
      end
   end
endmodule

/* File: omda_pkg.sv */
package omda_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int AI_CHANNELS = 16;
   localparam int AO_CHANNELS = 4;
   localparam int DIO_LINES = 4;
   localparam int AI_RANGES = 4;
   localparam int FIRST_SE_ONLY_CH = 8;
   localparam int AI_CAL_WIDTH = 24;
   localparam int AI_CAL_INT_BITS = 5;
   localparam int AO_CAL_WIDTH = 20;
   localparam int AO_CAL_INT_BITS = 5;
   localparam int CONST_WIDTH = 32;
   localparam int CH_IDX_WIDTH = 4;
   localparam int AO_IDX_WIDTH = 2;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_GAP_US = 8;
   localparam int CONV_GAP_CYCLES = (CONV_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_CYCLES = 16;
   localparam int CNT_WIDTH = 16;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [DIO_LINES-1:0] DIO_DIR_RESET = 4'h0;
   localparam logic [DIO_LINES-1:0] DIO_OUT_RESET = 4'h0;

   typedef enum logic
   {
      OMDA_SINGLE_ENDED_REF,
      OMDA_DIFFERENTIAL_PAIR
   } omda_term_e;

   typedef enum logic [1:0]
   {
      OMDA_RANGE_10V,
      OMDA_RANGE_5V,
      OMDA_RANGE_2V,
      OMDA_RANGE_1V
   } omda_range_e;

   // per-channel analog input setting request
   typedef struct packed
   {
      logic set_term;
      logic set_range;
      logic [CH_IDX_WIDTH-1:0] chan;
      omda_term_e term;
      omda_range_e range;
   } omda_ai_cfg_s;

   // digital write request
   typedef struct packed
   {
      logic wr;
      logic [DIO_LINES-1:0] data;
      logic set_dir;
      logic [DIO_LINES-1:0] dir;
   } omda_dio_req_s;
endpackage

/* File: omda_top.sv */
`timescale 1ns/1ps
module omda_top
#(
   parameter int INIT_LEN = omda_pkg::INIT_CYCLES,
   parameter int CONV_GAP = omda_pkg::CONV_GAP_CYCLES,
   parameter logic [omda_pkg::CONST_WIDTH*omda_pkg::AO_CHANNELS-1:0] AO_GAIN_NV = '0,
   parameter logic [omda_pkg::CONST_WIDTH*omda_pkg::AO_CHANNELS-1:0] AO_OFFSET_NV = '0,
   parameter logic [omda_pkg::CONST_WIDTH*omda_pkg::AI_RANGES-1:0] AI_GAIN_PV = '0,
   parameter logic [omda_pkg::CONST_WIDTH*omda_pkg::AI_RANGES-1:0] AI_OFFSET_NV = '0
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic loop_active,
   input wire logic out_zero_stage,
   input wire logic ai_cal_mode,
   input wire logic [omda_pkg::DIO_LINES-1:0] default_dir,
   input wire omda_pkg::omda_dio_req_s dio_req,
   input wire logic [omda_pkg::DIO_LINES-1:0] dio_pin_in,
   output logic [omda_pkg::DIO_LINES-1:0] dio_pin_out,
   output logic [omda_pkg::DIO_LINES-1:0] dio_pin_oe,
   output logic dio_ready,
   output logic [omda_pkg::DIO_LINES-1:0] dio_in_data,
   output logic dio_in_valid,
   input wire omda_pkg::omda_ai_cfg_s ai_cfg,
   output logic ai_cfg_reject,
   output logic [omda_pkg::AI_CHANNELS-1:0] ai_term_differential_pair,
   output logic [2*omda_pkg::AI_CHANNELS-1:0] ai_range,
   input wire logic ai_conv_req,
   input wire logic [omda_pkg::CH_IDX_WIDTH-1:0] ai_conv_chan,
   output logic ai_conv_start,
   output logic [omda_pkg::CH_IDX_WIDTH-1:0] ai_conv_sel,
   output logic ai_conv_busy,
   input wire logic ai_adc_valid,
   input wire logic signed [omda_pkg::AI_CAL_WIDTH-1:0] ai_adc_code,
   output logic ai_data_valid,
   output logic signed [omda_pkg::AI_CAL_WIDTH-1:0] ai_data,
   output logic ai_data_cal,
   input wire logic ao_wr,
   input wire logic signed [omda_pkg::AO_CAL_WIDTH-1:0] ao_value,
   input wire logic [omda_pkg::AO_IDX_WIDTH-1:0] ao_chan,
   output logic ao_wr_out,
   output logic signed [omda_pkg::AO_CAL_WIDTH-1:0] ao_value_out,
   output logic [omda_pkg::AO_IDX_WIDTH-1:0] ao_chan_out,
   input wire logic [omda_pkg::AO_IDX_WIDTH-1:0] cal_ao_sel,
   input wire omda_pkg::omda_range_e cal_ai_sel,
   output logic [omda_pkg::CONST_WIDTH-1:0] ao_gain_nv,
   output logic [omda_pkg::CONST_WIDTH-1:0] ao_offset_nv,
   output logic [omda_pkg::CONST_WIDTH-1:0] ai_gain_pv,
   output logic [omda_pkg::CONST_WIDTH-1:0] ai_offset_nv
);
   import omda_pkg::*;

   // ---------------------------------------------------------------
   // readiness
   // ---------------------------------------------------------------
   logic [CNT_WIDTH-1:0] init_cnt_reg, init_cnt_next;
   logic ready_reg, ready_next;

   // ready rises once the init count has run out, registered in clk
   always_comb
   begin
      init_cnt_next = init_cnt_reg;
      ready_next = ready_reg;
      if (init_cnt_reg == CNT_WIDTH'(INIT_LEN - 1))
         ready_next = 1'b1;
      else
         init_cnt_next = init_cnt_reg + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         init_cnt_reg <= '0;
         ready_reg <= 1'b0;
      end
      else
      begin
         init_cnt_reg <= init_cnt_next;
         ready_reg <= ready_next;
      end
   end
   assign dio_ready = ready_reg;

   // ---------------------------------------------------------------
   // digital lines
   // ---------------------------------------------------------------
   logic [DIO_LINES-1:0] in_meta_reg, in_sync_reg;
   logic [DIO_LINES-1:0] in_data_reg, in_data_next;
   logic in_valid_reg, in_valid_next;
   logic [DIO_LINES-1:0] dir_reg, dir_next;
   logic [DIO_LINES-1:0] stage_reg, stage_next;
   logic [DIO_LINES-1:0] pin_out_reg, pin_out_next;
   logic dir_init_reg, dir_init_next;

   // pin inputs pass two flops before anything reads them
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         in_meta_reg <= '0;
         in_sync_reg <= '0;
      end
      else
      begin
         in_meta_reg <= dio_pin_in;
         in_sync_reg <= in_meta_reg;
      end
   end

   // direction is taken from default once after reset, then only outside the loop
   always_comb
   begin
      in_data_next = in_sync_reg;
      in_valid_next = ready_reg;
      dir_next = dir_reg;
      dir_init_next = 1'b1;
      stage_next = stage_reg;
      pin_out_next = pin_out_reg;
      if (!dir_init_reg)
         dir_next = default_dir;
      else if (dio_req.set_dir && !loop_active && ready_reg)
         dir_next = dio_req.dir;
      if (dio_req.wr && ready_reg)
         stage_next = dio_req.data;
      // zero stages only honoured in the loop; the fast path skips one flop
      if (loop_active && out_zero_stage && dio_req.wr && ready_reg)
         pin_out_next = dio_req.data;
      else
         pin_out_next = stage_reg;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         in_data_reg <= '0;
         in_valid_reg <= 1'b0;
         dir_reg <= DIO_DIR_RESET;
         dir_init_reg <= 1'b0;
         stage_reg <= DIO_OUT_RESET;
         pin_out_reg <= DIO_OUT_RESET;
      end
      else
      begin
         in_data_reg <= in_data_next;
         in_valid_reg <= in_valid_next;
         dir_reg <= dir_next;
         dir_init_reg <= dir_init_next;
         stage_reg <= stage_next;
         pin_out_reg <= pin_out_next;
      end
   end
   assign dio_in_data = in_data_reg;
   assign dio_in_valid = in_valid_reg;
   assign dio_pin_out = pin_out_reg;
   assign dio_pin_oe = dir_reg;

   // ---------------------------------------------------------------
   // analog input settings
   // ---------------------------------------------------------------
   logic [AI_CHANNELS-1:0] term_reg, term_next;
   logic [2*AI_CHANNELS-1:0] range_reg, range_next;
   logic rej_reg, rej_next;

   // a setting is a one-cycle request; refusals show as a one-cycle pulse
   always_comb
   begin
      term_next = term_reg;
      range_next = range_reg;
      rej_next = 1'b0;
      if ((ai_cfg.set_term || ai_cfg.set_range) && loop_active)
         rej_next = 1'b1;
      else
      begin
         if (ai_cfg.set_term)
         begin
            if (ai_cfg.term == OMDA_DIFFERENTIAL_PAIR
                && ai_cfg.chan >= CH_IDX_WIDTH'(FIRST_SE_ONLY_CH))
               rej_next = 1'b1;
            else
               term_next[ai_cfg.chan] = (ai_cfg.term == OMDA_DIFFERENTIAL_PAIR);
         end
         if (ai_cfg.set_range)
            range_next[2*ai_cfg.chan +: 2] = ai_cfg.range;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         term_reg <= '0;
         range_reg <= '0;
         rej_reg <= 1'b0;
      end
      else
      begin
         term_reg <= term_next;
         range_reg <= range_next;
         rej_reg <= rej_next;
      end
   end
   assign ai_term_differential_pair = term_reg;
   assign ai_range = range_reg;
   assign ai_cfg_reject = rej_reg;

   // ---------------------------------------------------------------
   // conversion pacing and results
   // ---------------------------------------------------------------
   logic [CNT_WIDTH-1:0] gap_reg, gap_next;
   logic pend_reg, pend_next;
   logic [CH_IDX_WIDTH-1:0] sel_reg, sel_next;
   logic start_reg, start_next;
   logic dval_reg, dval_next;
   logic signed [AI_CAL_WIDTH-1:0] data_reg, data_next;
   logic cal_reg, cal_next;

   // an early request waits in pend until the gap counter expires
   always_comb
   begin
      gap_next = (gap_reg != '0) ? gap_reg - 1'b1 : gap_reg;
      pend_next = pend_reg;
      sel_next = sel_reg;
      start_next = 1'b0;
      if (ai_conv_req && !loop_active && !pend_reg)
      begin
         pend_next = 1'b1;
         sel_next = ai_conv_chan;
      end
      // a request left waiting from before the loop must not start inside it
      if ((pend_reg || ai_conv_req) && !loop_active && gap_reg == '0)
      begin
         start_next = 1'b1;
         pend_next = 1'b0;
         gap_next = CNT_WIDTH'(CONV_GAP - 1);
         if (!pend_reg)
            sel_next = ai_conv_chan;
      end
      // converter codes pass through; calibrated flag marks the fixed-point format
      dval_next = ai_adc_valid;
      data_next = ai_adc_valid ? ai_adc_code : data_reg;
      cal_next = ai_cal_mode;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         gap_reg <= '0;
         pend_reg <= 1'b0;
         sel_reg <= '0;
         start_reg <= 1'b0;
         dval_reg <= 1'b0;
         data_reg <= '0;
         cal_reg <= 1'b0;
      end
      else
      begin
         gap_reg <= gap_next;
         pend_reg <= pend_next;
         sel_reg <= sel_next;
         start_reg <= start_next;
         dval_reg <= dval_next;
         data_reg <= data_next;
         cal_reg <= cal_next;
      end
   end
   assign ai_conv_start = start_reg;
   assign ai_conv_sel = sel_reg;
   assign ai_conv_busy = pend_reg;
   assign ai_data_valid = dval_reg;
   assign ai_data = data_reg;
   assign ai_data_cal = cal_reg;

   // ---------------------------------------------------------------
   // analog output and calibration constants
   // ---------------------------------------------------------------
   logic ao_wr_reg, ao_wr_next;
   logic signed [AO_CAL_WIDTH-1:0] ao_val_reg, ao_val_next;
   logic [AO_IDX_WIDTH-1:0] ao_ch_reg, ao_ch_next;
   logic [CONST_WIDTH-1:0] k0_reg, k1_reg, k2_reg, k3_reg;
   logic [CONST_WIDTH-1:0] k0_next, k1_next, k2_next, k3_next;

   // output writes inside the loop are refused; constants are table lookups
   always_comb
   begin
      ao_wr_next = ao_wr && !loop_active;
      ao_val_next = (ao_wr && !loop_active) ? ao_value : ao_val_reg;
      ao_ch_next = (ao_wr && !loop_active) ? ao_chan : ao_ch_reg;
      k0_next = AO_GAIN_NV[CONST_WIDTH*cal_ao_sel +: CONST_WIDTH];
      k1_next = AO_OFFSET_NV[CONST_WIDTH*cal_ao_sel +: CONST_WIDTH];
      k2_next = AI_GAIN_PV[CONST_WIDTH*cal_ai_sel +: CONST_WIDTH];
      k3_next = AI_OFFSET_NV[CONST_WIDTH*cal_ai_sel +: CONST_WIDTH];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ao_wr_reg <= 1'b0;
         ao_val_reg <= '0;
         ao_ch_reg <= '0;
         k0_reg <= '0;
         k1_reg <= '0;
         k2_reg <= '0;
         k3_reg <= '0;
      end
      else
      begin
         ao_wr_reg <= ao_wr_next;
         ao_val_reg <= ao_val_next;
         ao_ch_reg <= ao_ch_next;
         k0_reg <= k0_next;
         k1_reg <= k1_next;
         k2_reg <= k2_next;
         k3_reg <= k3_next;
      end
   end
   assign ao_wr_out = ao_wr_reg;
   assign ao_value_out = ao_val_reg;
   assign ao_chan_out = ao_ch_reg;
   assign ao_gain_nv = k0_reg;
   assign ao_offset_nv = k1_reg;
   assign ai_gain_pv = k2_reg;
   assign ai_offset_nv = k3_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_req_early;
      ai_conv_start ##1 (gap_reg != '0);
   endsequence

   a_ready_reset_low: assert property (@(posedge clk) $past(sys_rst) |-> !dio_ready)
      else $error("ready high right after reset");
   a_ready_sticks: assert property (@(posedge clk) disable iff (sys_rst)
      dio_ready |=> dio_ready)
      else $error("ready dropped without reset");
   a_differential_pair_refused: assert property (@(posedge clk) disable iff (sys_rst)
      ai_term_differential_pair[AI_CHANNELS-1:FIRST_SE_ONLY_CH] == '0)
      else $error("differential on a single-ended-only channel");
   a_range_taken: assert property (@(posedge clk) disable iff (sys_rst)
      ai_cfg.set_range && !loop_active |=> ai_range[2*$past(ai_cfg.chan) +: 2] == $past(ai_cfg.range))
      else $error("range not applied");
   a_loop_no_analog: assert property (@(posedge clk) disable iff (sys_rst)
      loop_active && ao_wr |=> !ao_wr_out)
      else $error("analog write inside loop");
   a_dir_frozen: assert property (@(posedge clk) disable iff (sys_rst)
      dir_init_reg && loop_active |=> $stable(dio_pin_oe))
      else $error("direction changed in loop");
   a_zero_stage: assert property (@(posedge clk) disable iff (sys_rst)
      loop_active && out_zero_stage && dio_req.wr && dio_ready
      |=> dio_pin_out == $past(dio_req.data))
      else $error("zero-stage path late");
   a_invalid_not_ready: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(dio_ready) |-> !dio_in_valid)
      else $error("input valid while not ready");
   a_drop_not_ready: assert property (@(posedge clk) disable iff (sys_rst)
      !dio_ready |=> $stable(stage_reg))
      else $error("write accepted while not ready");
   a_conv_gap: assert property (@(posedge clk) disable iff (sys_rst)
      s_req_early |-> !ai_conv_start)
      else $error("conversions too close");
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   import omda_pkg::*;
   // ---------------------------------------------------------------
   // short counts keep the run brief
   // ---------------------------------------------------------------
   localparam int INIT_LEN = 8;
   localparam int CONV_GAP = 5;
   logic clk, sys_rst, loop_active, out_zero_stage, ai_cal_mode;
   logic [DIO_LINES-1:0] default_dir, dio_pin_in, dio_pin_out, dio_pin_oe, dio_in_data, ext_level;
   logic dio_ready, dio_in_valid, ai_cfg_reject, ai_conv_req, ai_conv_start, ai_conv_busy;
   logic ai_adc_valid, ai_data_valid, ai_data_cal, ao_wr, ao_wr_out;
   omda_dio_req_s dio_req;
   omda_ai_cfg_s ai_cfg;
   logic [AI_CHANNELS-1:0] ai_term_differential_pair;
   logic [2*AI_CHANNELS-1:0] ai_range, exp_range;
   logic [CH_IDX_WIDTH-1:0] ai_conv_chan, ai_conv_sel;
   logic signed [AI_CAL_WIDTH-1:0] ai_adc_code, ai_data;
   logic signed [AO_CAL_WIDTH-1:0] ao_value, ao_value_out;
   logic [AO_IDX_WIDTH-1:0] ao_chan, ao_chan_out, cal_ao_sel;
   omda_range_e cal_ai_sel;
   logic [CONST_WIDTH-1:0] ao_gain_nv, ao_offset_nv, ai_gain_pv, ai_offset_nv;
   logic [AI_CAL_WIDTH:0] got_q[$];
   int miscompares, compares;
   // ---------------------------------------------------------------
   // design and far side
   // ---------------------------------------------------------------
   omda_top #(.INIT_LEN(INIT_LEN), .CONV_GAP(CONV_GAP),
      .AO_GAIN_NV({32'h0a03, 32'h0a02, 32'h0a01, 32'h0a00}),
      .AO_OFFSET_NV({32'h0b03, 32'h0b02, 32'h0b01, 32'h0b00}),
      .AI_GAIN_PV({32'h0c03, 32'h0c02, 32'h0c01, 32'h0c00}),
      .AI_OFFSET_NV({32'h0d03, 32'h0d02, 32'h0d01, 32'h0d00})) u_omda_top (
      .clk(clk), .sys_rst(sys_rst), .loop_active(loop_active),
      .out_zero_stage(out_zero_stage), .ai_cal_mode(ai_cal_mode), .default_dir(default_dir),
      .dio_req(dio_req), .dio_pin_in(dio_pin_in), .dio_pin_out(dio_pin_out),
      .dio_pin_oe(dio_pin_oe), .dio_ready(dio_ready), .dio_in_data(dio_in_data),
      .dio_in_valid(dio_in_valid), .ai_cfg(ai_cfg), .ai_cfg_reject(ai_cfg_reject),
      .ai_term_differential_pair(ai_term_differential_pair), .ai_range(ai_range), .ai_conv_req(ai_conv_req),
      .ai_conv_chan(ai_conv_chan), .ai_conv_start(ai_conv_start), .ai_conv_sel(ai_conv_sel),
      .ai_conv_busy(ai_conv_busy), .ai_adc_valid(ai_adc_valid), .ai_adc_code(ai_adc_code),
      .ai_data_valid(ai_data_valid), .ai_data(ai_data), .ai_data_cal(ai_data_cal),
      .ao_wr(ao_wr), .ao_value(ao_value), .ao_chan(ao_chan), .ao_wr_out(ao_wr_out),
      .ao_value_out(ao_value_out), .ao_chan_out(ao_chan_out), .cal_ao_sel(cal_ao_sel),
      .cal_ai_sel(cal_ai_sel), .ao_gain_nv(ao_gain_nv), .ao_offset_nv(ao_offset_nv),
      .ai_gain_pv(ai_gain_pv), .ai_offset_nv(ai_offset_nv));
   omda_far_model u_omda_far_model (.clk(clk), .sys_rst(sys_rst),
      .ai_conv_start(ai_conv_start), .ai_conv_sel(ai_conv_sel), .dio_pin_out(dio_pin_out),
      .dio_pin_oe(dio_pin_oe), .ext_level(ext_level), .ai_adc_valid(ai_adc_valid),
      .ai_adc_code(ai_adc_code), .dio_pin_in(dio_pin_in));
   // ---------------------------------------------------------------
   // helpers; inputs change at the falling edge only
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk_flag(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s got %b", $time, what, got);
      end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // one-cycle digital request; callers let an edge pass before the next one
   task automatic dio(input logic wr, input logic [3:0] d, input logic sd, input logic [3:0] dr);
      dio_req = '{wr: wr, data: d, set_dir: sd, dir: dr};
      @(negedge clk);
      dio_req = '0;
   endtask
   task automatic conv(input logic [3:0] ch);
      ai_conv_req = 1'b1;
      ai_conv_chan = ch;
      @(negedge clk);
      ai_conv_req = 1'b0;
   endtask
   // left raised so back-to-back settings need no gap; caller clears it
   task automatic cfg(input logic [3:0] ch, input omda_term_e t, input omda_range_e r);
      ai_cfg = '{set_term: 1'b1, set_range: 1'b1, chan: ch, term: t, range: r};
      @(negedge clk);
   endtask
   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // collect every returned sample as {calibrated flag, word}
   always @(negedge clk)
   begin
      if (ai_data_valid === 1'b1)
         got_q.push_back({ai_data_cal, ai_data});
   end
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // the whole sequence needs well under 2000 ns
   initial
   begin
      #20000;
      miscompares++;
      end_of_test();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      loop_active = 1'b0;
      out_zero_stage = 1'b0;
      ai_cal_mode = 1'b1;
      default_dir = 4'h3;
      dio_req = '0;
      ext_level = 4'h5;
      ai_cfg = '0;
      ai_conv_req = 1'b0;
      ai_conv_chan = 4'h0;
      ao_wr = 1'b0;
      ao_value = '0;
      ao_chan = 2'h0;
      cal_ao_sel = 2'h0;
      cal_ai_sel = OMDA_RANGE_10V;
      exp_range = '0;
      cyc(3);
      sys_rst = 1'b0;
      cyc(2);
      chk_word(dio_pin_oe, 4'h3, "oe default");
      chk_flag(dio_ready, 1'b0, "ready early");
      chk_flag(dio_in_valid, 1'b0, "in valid early");
      dio(1'b1, 4'hf, 1'b0, 4'h0);
      for (int i = 0; i < 20 && dio_ready !== 1'b1; i++)
         cyc(1);
      chk_flag(dio_ready, 1'b1, "ready");
      cyc(2);
      chk_word(dio_pin_out, 4'h0, "early write");
      chk_flag(dio_in_valid, 1'b1, "in valid");
      // outside the loop a zero-stage request still costs one stage
      out_zero_stage = 1'b1;
      dio(1'b0, 4'h0, 1'b1, 4'hf);
      cyc(1);
      chk_word(dio_pin_oe, 4'hf, "oe set");
      dio(1'b1, 4'ha, 1'b0, 4'h0);
      chk_word(dio_pin_out, 4'h0, "one stage");
      cyc(1);
      chk_word(dio_pin_out, 4'ha, "one stage");
      cyc(4);
      chk_word(dio_in_data, 4'ha, "read back");
      // inside the loop: zero or one stage, directions frozen
      loop_active = 1'b1;
      dio(1'b1, 4'h9, 1'b0, 4'h0);
      chk_word(dio_pin_out, 4'h9, "zero stage");
      cyc(1);
      dio(1'b0, 4'h0, 1'b1, 4'h0);
      cyc(1);
      chk_word(dio_pin_oe, 4'hf, "dir in loop");
      out_zero_stage = 1'b0;
      dio(1'b1, 4'h6, 1'b0, 4'h0);
      chk_word(dio_pin_out, 4'h9, "loop stage");
      cyc(1);
      chk_word(dio_pin_out, 4'h6, "loop stage");
      chk_word(dio_pin_oe, 4'hf, "write keeps dir");
      // analog access inside the loop is refused
      cfg(4'h0, OMDA_DIFFERENTIAL_PAIR, OMDA_RANGE_1V);
      ai_cfg = '0;
      chk_flag(ai_cfg_reject, 1'b1, "cfg in loop");
      ao_wr = 1'b1;
      ao_chan = 2'h1;
      ao_value = 20'sh00123;
      conv(4'h2);
      ao_wr = 1'b0;
      chk_flag(ao_wr_out, 1'b0, "ao in loop");
      chk_flag(ai_conv_start, 1'b0, "conv in loop");
      chk_word(ai_term_differential_pair, 16'h0000, "term in loop");
      chk_word(ai_range, 32'h0, "range in loop");
      loop_active = 1'b0;
      // every channel asks for differential, ranges walk all four codes
      for (int ch = 0; ch < AI_CHANNELS; ch++)
      begin
         cfg(4'(ch), OMDA_DIFFERENTIAL_PAIR, omda_range_e'(ch % 4));
         chk_flag(ai_cfg_reject, 1'(ch >= FIRST_SE_ONLY_CH), "differential_pair refusal");
         exp_range[2*ch +: 2] = 2'(ch % 4);
      end
      cfg(4'h0, OMDA_SINGLE_ENDED_REF, OMDA_RANGE_10V);
      ai_cfg = '0;
      cyc(1);
      chk_word(ai_term_differential_pair, 16'h00fe, "terms");
      chk_word(ai_range, exp_range, "ranges");
      // second request inside the gap waits for it
      conv(4'h3);
      chk_flag(ai_conv_start, 1'b1, "start");
      chk_word(ai_conv_sel, 4'h3, "sel");
      cyc(2);
      conv(4'h5);
      chk_flag(ai_conv_busy, 1'b1, "busy");
      chk_flag(ai_conv_start, 1'b0, "held");
      ai_cal_mode = 1'b0;
      cyc(1);
      chk_flag(ai_conv_start, 1'b0, "held");
      cyc(1);
      chk_flag(ai_conv_start, 1'b1, "gap start");
      chk_word(ai_conv_sel, 4'h5, "gap sel");
      cyc(6);
      chk_word(32'(got_q.size()), 32'h2, "samples");
      if (got_q.size() == 2)
      begin
         chk_word(got_q[0], {1'b1, 24'h0a0003}, "cal sample");
         chk_word(got_q[1], {1'b0, 24'h0a0005}, "raw sample");
      end
      ao_wr = 1'b1;
      ao_chan = 2'h2;
      ao_value = 20'sh80001;
      cyc(1);
      ao_wr = 1'b0;
      chk_flag(ao_wr_out, 1'b1, "ao wr");
      chk_word({12'h0, ao_value_out}, 32'h80001, "ao value");
      chk_word(ao_chan_out, 2'h2, "ao chan");
      // every output channel and input range has its own constants
      for (int i = 0; i < 4; i++)
      begin
         cal_ao_sel = 2'(i);
         cal_ai_sel = omda_range_e'(i);
         cyc(1);
         chk_word(ao_gain_nv, 32'h0a00 + i, "ao gain");
         chk_word(ao_offset_nv, 32'h0b00 + i, "ao offset");
         chk_word(ai_gain_pv, 32'h0c00 + i, "ai gain");
         chk_word(ai_offset_nv, 32'h0d00 + i, "ai offset");
      end
      // a second reset drops ready and reloads the default directions
      default_dir = 4'h5;
      sys_rst = 1'b1;
      cyc(2);
      sys_rst = 1'b0;
      cyc(2);
      chk_flag(dio_ready, 1'b0, "ready after reset");
      chk_flag(dio_in_valid, 1'b0, "valid after reset");
      chk_word(dio_pin_oe, 4'h5, "oe after reset");
      chk_word(dio_pin_out, 4'h0, "out after reset");
      end_of_test();
   end
endmodule
